// File: include/tamc_map.vh
`ifndef TAMC_MAP_VH
`define TAMC_MAP_VH

// register byte offsets
`define TAMC_CTRL_OFS 8'h00
`define TAMC_STAT_OFS 8'h04
`define TAMC_RSLT_OFS 8'h08

// control register fields
`define TAMC_CTRL_PEN_EN 0
`define TAMC_CTRL_RESET 32'h0000_0000

// status register fields
`define TAMC_STAT_BUSY 0
`define TAMC_STAT_TRACK 1
`define TAMC_STAT_PEN_PIN 2
`define TAMC_STAT_STATE_LO 4

// result register fields
`define TAMC_RSLT_CTRL_LO 16
`define TAMC_RSLT_NEW 31

// axi responses
`define TAMC_RESP_OKAY 2'h0
`define TAMC_RESP_SLVERR 2'h2

// control byte bit positions, start bit is bit 7
`define TAMC_CB_START 7
`define TAMC_CB_MODE_SE 2

// rising-edge count before the edge that completes channel or mode bits
`define TAMC_RISE_CHAN 5'h03
`define TAMC_RISE_MODE 5'h05
`define TAMC_CTRL_BITS 5'h08

// falling-edge counts from the start bit
`define TAMC_FALL_ACQ 5'h05
`define TAMC_FALL_CONV 5'h08
`define TAMC_FALL_MSB 5'h09
`define TAMC_FALL_LAST 5'h14

// channel codes
`define TAMC_CH_YPOS 3'h1
`define TAMC_CH_AUXA 3'h2
`define TAMC_CH_XPOS 3'h5
`define TAMC_CH_AUXB 3'h6

// converter input select
`define TAMC_AIN_NONE 3'h0
`define TAMC_AIN_XH 3'h1
`define TAMC_AIN_YH 3'h2
`define TAMC_AIN_AUXA 3'h3
`define TAMC_AIN_AUXB 3'h4

// reference select
`define TAMC_REF_EXT 2'h0
`define TAMC_REF_YPINS 2'h1
`define TAMC_REF_XPINS 2'h2

`endif

// File: rtl/tamc_ctrl.v
// Functional notes
// - sample data in on serial clock rise
// - data out changes only on falling edges and on deselect
// - accept input bits only with select low
// - select high releases data out and busy
// - busy high one period before msb decision
// - host serial clock paces every conversion step
// - twelve-bit result by successive approximation
// - track input from fifth to eighth fall
// - mode bit one single-ended, zero differential
// - single-ended uses external reference and ground
// - single-ended position codes route panel and drivers
// - differential position codes use panel references
// - leading zeros ignored, first one starts
// - pen interrupt low on touch, masked mid-frame
// - result shifted out msb first, binary
`include "tamc_map.vh"

module tamc_ctrl #(
	parameter RES_BITS = 12,
	parameter ADDR_W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire serial_clock_in,
	input wire chip_select_n,
	input wire serial_data_in,
	output wire serial_data_out_o,
	output wire serial_data_out_oe,
	output wire busy_o,
	output wire busy_oe,
	input wire pen_touch_irq_n_i,
	output wire pen_touch_irq_n_o,
	output wire pen_touch_irq_n_oe,
	input wire pen_touched,
	input wire sar_cmp_in,
	output wire [RES_BITS-1:0] sar_trial,
	output wire track_en,
	output wire [2:0] adc_in_sel,
	output wire [1:0] adc_ref_sel,
	output wire drv_x_high_en,
	output wire drv_x_low_en,
	output wire drv_y_high_en,
	output wire drv_y_low_en
);

	localparam ST_HUNT = 2'd0;
	localparam ST_CTRL = 2'd1;
	localparam ST_CONV = 2'd2;
	localparam ST_DONE = 2'd3;

	// two-stage synchronisers: clk, cs_n, din, comparator, touch, pen pin
	reg [5:0] sync1_r;
	reg [5:0] sync2_r;
	reg sclk_d_r;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 6'h3e;
			sync2_r <= 6'h3e;
			sclk_d_r <= 1'b0;
		end else begin
			sync1_r <= {pen_touch_irq_n_i, pen_touched, sar_cmp_in,
				serial_data_in, chip_select_n, serial_clock_in};
			sync2_r <= sync1_r;
			sclk_d_r <= sync2_r[0];
		end
	end

	wire sclk_s = sync2_r[0];
	wire cs_act = ~sync2_r[1];
	wire din_s = sync2_r[2];
	wire cmp_s = sync2_r[3];
	wire touch_s = sync2_r[4];
	wire pen_pin_s = sync2_r[5];
	// edges are only meaningful while selected
	wire sclk_rise = cs_act & sclk_s & ~sclk_d_r;
	wire sclk_fall = cs_act & ~sclk_s & sclk_d_r;

	reg [1:0] state_r, state_nxt;
	reg [7:0] shreg_r, shreg_nxt;
	reg [4:0] rise_cnt_r, rise_cnt_nxt;
	reg [4:0] fall_cnt_r, fall_cnt_nxt;
	reg [2:0] chan_r, chan_nxt;
	reg mode_se_r, mode_se_nxt;
	reg [RES_BITS-1:0] sar_r, sar_nxt;
	reg [RES_BITS-1:0] mask_r, mask_nxt;
	reg [RES_BITS-1:0] result_r, result_nxt;
	reg [7:0] ctrl_byte_r, ctrl_byte_nxt;
	reg dout_r, dout_nxt;
	reg busy_r, busy_nxt;
	reg track_r, track_nxt;
	reg [2:0] ain_r, ain_nxt;
	reg [1:0] ref_r, ref_nxt;
	reg [3:0] drv_r, drv_nxt;
	reg done_ev;
	// keep the trial bit when the comparator says the input is at or above it
	function [RES_BITS-1:0] sar_decide;
		input [RES_BITS-1:0] trial;
		input [RES_BITS-1:0] bit_mask;
		input keep;
		sar_decide = keep ? trial : (trial & ~bit_mask);
	endfunction

	always @* begin
		state_nxt = state_r;
		shreg_nxt = shreg_r;
		rise_cnt_nxt = rise_cnt_r;
		fall_cnt_nxt = fall_cnt_r;
		chan_nxt = chan_r;
		mode_se_nxt = mode_se_r;
		sar_nxt = sar_r;
		mask_nxt = mask_r;
		result_nxt = result_r;
		ctrl_byte_nxt = ctrl_byte_r;
		dout_nxt = dout_r;
		busy_nxt = busy_r;
		track_nxt = track_r;
		{ain_nxt, ref_nxt, drv_nxt} = {ain_r, ref_r, drv_r};
		done_ev = 1'b0;
		if (!cs_act) begin
			// deselect abandons the frame and idles the switches
			state_nxt = ST_HUNT;
			rise_cnt_nxt = 5'h00;
			fall_cnt_nxt = 5'h00;
			{dout_nxt, busy_nxt, track_nxt} = 3'h0;
			{ain_nxt, ref_nxt, drv_nxt} = {`TAMC_AIN_NONE, `TAMC_REF_EXT, 4'h0};
		end else if (sclk_rise) begin
			case (state_r)
				ST_HUNT, ST_DONE: begin
					if (din_s) begin
						state_nxt = ST_CTRL;
						shreg_nxt = 8'h01;
						rise_cnt_nxt = 5'h01;
						fall_cnt_nxt = 5'h00;
					end
				end
				ST_CTRL: begin
					if (rise_cnt_r < `TAMC_CTRL_BITS) begin
						shreg_nxt = {shreg_r[6:0], din_s};
						rise_cnt_nxt = rise_cnt_r + 5'h01;
						if (rise_cnt_r == `TAMC_RISE_CHAN)
							chan_nxt = {shreg_r[1:0], din_s};
						if (rise_cnt_r == `TAMC_RISE_MODE)
							mode_se_nxt = din_s;
					end
				end
				default: shreg_nxt = shreg_r; // data bits mid-conversion carry no meaning
			endcase
		end else if (sclk_fall && (state_r == ST_CTRL || state_r == ST_CONV)) begin
			fall_cnt_nxt = fall_cnt_r + 5'h01;
			if (fall_cnt_nxt == `TAMC_FALL_ACQ) begin
				track_nxt = 1'b1;
				case (chan_r)
					`TAMC_CH_YPOS: {ain_nxt, drv_nxt} = {`TAMC_AIN_XH, 4'h3};
					`TAMC_CH_XPOS: {ain_nxt, drv_nxt} = {`TAMC_AIN_YH, 4'hc};
					`TAMC_CH_AUXA: {ain_nxt, drv_nxt} = {`TAMC_AIN_AUXA, 4'h0};
					`TAMC_CH_AUXB: {ain_nxt, drv_nxt} = {`TAMC_AIN_AUXB, 4'h0};
					default: {ain_nxt, drv_nxt} = {`TAMC_AIN_NONE, 4'h0};
				endcase
			end
			if (fall_cnt_nxt == `TAMC_FALL_CONV) begin
				// hold phase opens; busy marks the cycle before the msb
				track_nxt = 1'b0;
				busy_nxt = 1'b1;
				state_nxt = ST_CONV;
				ctrl_byte_nxt = shreg_r;
				sar_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
				mask_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
				if (!mode_se_r && chan_r == `TAMC_CH_YPOS)
					ref_nxt = `TAMC_REF_YPINS;
				else if (!mode_se_r && chan_r == `TAMC_CH_XPOS)
					ref_nxt = `TAMC_REF_XPINS;
				else
					ref_nxt = `TAMC_REF_EXT;
				// single-ended bias is dropped after acquisition to save power
				if (mode_se_r)
					drv_nxt = 4'h0;
			end
			if (fall_cnt_nxt >= `TAMC_FALL_MSB) begin
				busy_nxt = 1'b0;
				sar_nxt = sar_decide(sar_r, mask_r, cmp_s) | (mask_r >> 1);
				mask_nxt = mask_r >> 1;
				dout_nxt = cmp_s;
			end
			if (fall_cnt_nxt == `TAMC_FALL_LAST) begin
				state_nxt = ST_DONE;
				result_nxt = sar_decide(sar_r, mask_r, cmp_s);
				sar_nxt = result_nxt;
				done_ev = 1'b1;
				track_nxt = 1'b0;
				{ain_nxt, ref_nxt, drv_nxt} = {`TAMC_AIN_NONE, `TAMC_REF_EXT, 4'h0};
			end
		end else if (sclk_fall) begin
			// trailing bits after the lsb are zero
			dout_nxt = 1'b0;
		end
	end

	// every conversion step advances only on host clock edges
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_HUNT;
			shreg_r <= 8'h00;
			rise_cnt_r <= 5'h00;
			fall_cnt_r <= 5'h00;
			chan_r <= 3'h0;
			mode_se_r <= 1'b0;
			sar_r <= {RES_BITS{1'b0}};
			mask_r <= {RES_BITS{1'b0}};
			result_r <= {RES_BITS{1'b0}};
			ctrl_byte_r <= 8'h00;
			{dout_r, busy_r, track_r} <= 3'h0;
			{ain_r, ref_r, drv_r} <= {`TAMC_AIN_NONE, `TAMC_REF_EXT, 4'h0};
		end else begin
			state_r <= state_nxt;
			shreg_r <= shreg_nxt;
			rise_cnt_r <= rise_cnt_nxt;
			fall_cnt_r <= fall_cnt_nxt;
			chan_r <= chan_nxt;
			mode_se_r <= mode_se_nxt;
			sar_r <= sar_nxt;
			mask_r <= mask_nxt;
			result_r <= result_nxt;
			ctrl_byte_r <= ctrl_byte_nxt;
			dout_r <= dout_nxt;
			busy_r <= busy_nxt;
			track_r <= track_nxt;
			{ain_r, ref_r, drv_r} <= {ain_nxt, ref_nxt, drv_nxt};
		end
	end

	assign serial_data_out_o = dout_r;
	assign serial_data_out_oe = cs_act;
	assign busy_o = busy_r;
	assign busy_oe = cs_act;
	assign sar_trial = sar_r;
	assign track_en = track_r;
	assign adc_in_sel = ain_r;
	assign adc_ref_sel = ref_r;
	assign drv_x_high_en = drv_r[3];
	assign drv_x_low_en = drv_r[2];
	assign drv_y_high_en = drv_r[1];
	assign drv_y_low_en = drv_r[0];

	// register slave
	reg [31:0] ctrl_r;
	reg new_r;
	reg pen_drive_r;
	reg aw_got_r, w_got_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;

	assign s_axi_awready = ~aw_got_r;
	assign s_axi_wready = ~w_got_r;
	assign s_axi_arready = ~s_axi_rvalid;

	wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
	wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
	wire rslt_read = rd_fire & (s_axi_araddr == `TAMC_RSLT_OFS);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TAMC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `TAMC_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			ctrl_r <= `TAMC_CTRL_RESET;
			new_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_got_r) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_r) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_r == `TAMC_CTRL_OFS) begin
					s_axi_bresp <= `TAMC_RESP_OKAY;
					if (wstrb_r[0])
						ctrl_r[`TAMC_CTRL_PEN_EN] <= wdata_r[`TAMC_CTRL_PEN_EN];
				end else if (awaddr_r == `TAMC_STAT_OFS || awaddr_r == `TAMC_RSLT_OFS) begin
					s_axi_bresp <= `TAMC_RESP_OKAY;
				end else begin
					s_axi_bresp <= `TAMC_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `TAMC_RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				case (s_axi_araddr)
					`TAMC_CTRL_OFS: s_axi_rdata <= ctrl_r;
					`TAMC_STAT_OFS: begin
						s_axi_rdata[`TAMC_STAT_BUSY] <= busy_r;
						s_axi_rdata[`TAMC_STAT_TRACK] <= track_r;
						s_axi_rdata[`TAMC_STAT_PEN_PIN] <= pen_pin_s;
						s_axi_rdata[`TAMC_STAT_STATE_LO+1:`TAMC_STAT_STATE_LO] <= state_r;
					end
					`TAMC_RSLT_OFS: begin
						s_axi_rdata[RES_BITS-1:0] <= result_r;
						s_axi_rdata[`TAMC_RSLT_CTRL_LO+7:`TAMC_RSLT_CTRL_LO] <= ctrl_byte_r;
						s_axi_rdata[`TAMC_RSLT_NEW] <= new_r;
					end
					default: s_axi_rresp <= `TAMC_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			// a finished conversion beats a simultaneous clearing read
			if (done_ev)
				new_r <= 1'b1;
			else if (rslt_read)
				new_r <= 1'b0;
		end
	end

	// open-drain pen line: masked from select low until the lsb is out
	always @(posedge aclk) begin
		if (!aresetn)
			pen_drive_r <= 1'b0;
		else
			pen_drive_r <= ctrl_r[`TAMC_CTRL_PEN_EN] & touch_s &
				(~cs_act | (state_r == ST_DONE));
	end

	assign pen_touch_irq_n_o = 1'b0;
	assign pen_touch_irq_n_oe = pen_drive_r;

endmodule

// File: verification/tamc_ctrl_props.sv
`include "tamc_map.vh"
module tamc_ctrl_props #(
	parameter RES_BITS = 12
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire serial_clock_in,
	input wire chip_select_n,
	input wire serial_data_out_o,
	input wire serial_data_out_oe,
	input wire busy_o,
	input wire busy_oe,
	input wire pen_touch_irq_n_oe,
	input wire [RES_BITS-1:0] sar_trial,
	input wire track_en,
	input wire [2:0] adc_in_sel,
	input wire drv_x_high_en,
	input wire drv_x_low_en,
	input wire drv_y_high_en,
	input wire drv_y_low_en
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	// five samples leave room for the select synchroniser
	out_release_a: assert property (chip_select_n [*5] |-> !serial_data_out_oe && !busy_oe)
		else $error("outputs driven while deselected");
	dout_fall_a: assert property ($changed(serial_data_out_o) |-> !$past(serial_clock_in, 2))
		else $error("data out moved off a falling edge");
	busy_width_a: assert property ($rose(busy_o) |-> busy_o [*8] ##1 !busy_o)
		else $error("busy not one serial period");
	busy_msb_a: assert property ($rose(busy_o) |-> sar_trial == (1 << (RES_BITS - 1)) && !track_en)
		else $error("busy not before msb trial");
	track_span_a: assert property ($rose(track_en) |-> ##23 track_en ##1 (!track_en && busy_o))
		else $error("track window wrong");
	aux_nodrv_a: assert property ((adc_in_sel == `TAMC_AIN_AUXA || adc_in_sel == `TAMC_AIN_AUXB)
		|-> !(drv_x_high_en | drv_x_low_en | drv_y_high_en | drv_y_low_en))
		else $error("driver on for aux input");
	pen_mask_a: assert property (busy_o |-> !pen_touch_irq_n_oe)
		else $error("pen line pulled during conversion");
	cover property ($rose(busy_o));
	cover property ($rose(track_en));
	cover property ($rose(pen_touch_irq_n_oe));
endmodule
bind tamc_ctrl tamc_ctrl_props #(.RES_BITS(RES_BITS)) u_props (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n),
	.serial_data_out_o(serial_data_out_o), .serial_data_out_oe(serial_data_out_oe),
	.busy_o(busy_o), .busy_oe(busy_oe), .pen_touch_irq_n_oe(pen_touch_irq_n_oe),
	.sar_trial(sar_trial), .track_en(track_en), .adc_in_sel(adc_in_sel),
	.drv_x_high_en(drv_x_high_en), .drv_x_low_en(drv_x_low_en),
	.drv_y_high_en(drv_y_high_en), .drv_y_low_en(drv_y_low_en)
);

// File: verification/tamc_host.sv
module tamc_host (
	output logic serial_clock_in,
	output logic chip_select_n,
	output logic serial_data_in,
	input wire sdo_line
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serial_clock_in = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// clock pulses with select high must be ignored
	task noise;
		#7 serial_data_in = 1'b1;
		repeat (3) begin
			#100 serial_clock_in = 1'b1;
			#100 serial_clock_in = 1'b0;
		end
	endtask
	// sclk stands still outside frames except in noise; the 7 ns offset keeps its edges off aclk edges
	task frame(input logic [7:0] cb, input int lz, output logic [11:0] res);
		logic [23:0] word;
		int i;
		begin
			word = {cb, 16'h0000};
			#7 chip_select_n = 1'b0;
			#100;
			for (i = 0; i < lz + 24; i++) begin
				serial_data_in = (i < lz) ? 1'b0 : word[23 - (i - lz)];
				#100 serial_clock_in = 1'b1;
				if (i - lz >= 9 && i - lz <= 20) res = {res[10:0], sdo_line};
				#100 serial_clock_in = 1'b0;
			end
			#100 chip_select_n = 1'b1;
			serial_data_in = ~serial_data_in;
		end
	endtask
endmodule

// File: verification/tb_top.sv
`include "tamc_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic pen_touched;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] rr;
	logic [11:0] target, res;
	logic [19:0] c;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire serial_clock_in, chip_select_n, serial_data_in, serial_data_out_o, serial_data_out_oe;
	wire busy_o, busy_oe, pen_touch_irq_n_o, pen_touch_irq_n_oe, track_en;
	wire [11:0] sar_trial;
	wire [2:0] adc_in_sel;
	wire [1:0] adc_ref_sel;
	wire drv_x_high_en, drv_x_low_en, drv_y_high_en, drv_y_low_en;
	// undriven data line shows the inverse so a stale bit never passes
	wire sdo_line = serial_data_out_oe ? serial_data_out_o : ~serial_data_out_o;
	// pull-up holds the pen line high whenever it is released
	wire pen_touch_irq_n_i = pen_touch_irq_n_oe ? pen_touch_irq_n_o : 1'b1;
	wire sar_cmp_in = target >= sar_trial;
	int miscompares = 0, n_checks = 0, cyc = 0, i;
	// cb, input select, reference select, drivers xh xl yh yl
	localparam logic [19:0] cases [10] = '{20'h9_4103, 20'ha_4300, 20'hd_420c, 20'he_4400,
		20'h8_4000, 20'hb_4000, 20'hc_4000, 20'hf_4000, 20'h9_0113, 20'hd_022c};
	tamc_ctrl dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .serial_clock_in(serial_clock_in),
		.chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
		.serial_data_out_o(serial_data_out_o), .serial_data_out_oe(serial_data_out_oe),
		.busy_o(busy_o), .busy_oe(busy_oe), .pen_touch_irq_n_i(pen_touch_irq_n_i),
		.pen_touch_irq_n_o(pen_touch_irq_n_o), .pen_touch_irq_n_oe(pen_touch_irq_n_oe),
		.pen_touched(pen_touched), .sar_cmp_in(sar_cmp_in), .sar_trial(sar_trial),
		.track_en(track_en), .adc_in_sel(adc_in_sel), .adc_ref_sel(adc_ref_sel),
		.drv_x_high_en(drv_x_high_en), .drv_x_low_en(drv_x_low_en),
		.drv_y_high_en(drv_y_high_en), .drv_y_low_en(drv_y_low_en)
	);
	tamc_host host (
		.serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in), .sdo_line(sdo_line)
	);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, ta, tw;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			pa = 1'b1;
			pw = 1'b1;
			while (pa || pw) begin
				@(negedge aclk);
				ta = pa && s_axi_awready;
				tw = pw && s_axi_wready;
				@(posedge aclk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
				pa = pa && !ta;
				pw = pw && !tw;
			end
			do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
			chk(s_axi_bresp, er, "write response");
			@(posedge aclk);
			s_axi_bready <= 1'b0;
		end
	endtask
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		s_axi_wstrb = 4'hf;
		target = 12'h000;
		pen_touched = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		axr(`TAMC_CTRL_OFS, rd, rr);
		chk(rd, `TAMC_CTRL_RESET, "control reset");
		axr(8'h0c, rd, rr);
		chk(rr, `TAMC_RESP_SLVERR, "unmapped read response");
		chk(rd, 32'h0000_0000, "unmapped read data");
		axw(8'h0c, 32'h0000_0001, `TAMC_RESP_SLVERR);
		pen_touched <= 1'b1;
		axw(`TAMC_CTRL_OFS, 32'h0000_0001, `TAMC_RESP_OKAY);
		repeat (8) @(posedge aclk);
		chk(pen_touch_irq_n_oe, 1'b1, "pen pull");
		axr(`TAMC_STAT_OFS, rd, rr);
		chk(rd[`TAMC_STAT_PEN_PIN], 1'b0, "pen pin level");
		$display("test pen done");
		host.noise();
		axr(`TAMC_STAT_OFS, rd, rr);
		chk({rd[5:4], rd[1:0]}, 4'h0, "idle while deselected");
		$display("test deselect done");
		for (i = 0; i < 10; i++) begin
			c = cases[i];
			@(posedge aclk);
			target <= 12'hfff - 12'h1c3 * i[11:0];
			fork
				host.frame(c[19:12], i % 4, res);
				begin
					wait (track_en === 1'b1);
					#1;
					chk(adc_in_sel, c[10:8], "input select");
					chk({drv_x_high_en, drv_x_low_en, drv_y_high_en, drv_y_low_en}, c[3:0], "drivers");
					wait (busy_o === 1'b1);
					#1;
					chk(adc_ref_sel, c[5:4], "reference");
				end
			join
			if (c[10:8] != 3'h0) chk(res, target, "serial result");
			axr(`TAMC_RSLT_OFS, rd, rr);
			chk({rd[31], rd[23:16]}, {1'b1, c[19:12]}, "result register");
			if (c[10:8] != 3'h0) chk(rd[11:0], target, "result value");
			$display("test %0d done", i);
		end
		repeat (8) @(posedge aclk);
		chk(pen_touch_irq_n_oe, 1'b1, "pen after frames");
		axw(`TAMC_CTRL_OFS, 32'h0000_0000, `TAMC_RESP_OKAY);
		repeat (8) @(posedge aclk);
		chk(pen_touch_irq_n_oe, 1'b0, "pen disabled");
		$display("test pen mask done");
		final_report();
	end
endmodule
